//--- logic/ssn_pkg.sv
package ssn_pkg;

    localparam int NUM_SLOTS = 14;
    localparam int NUM_KINDS = 5;
    localparam int DSG_W = 8;

    // Slot indices, A through N in scan order
    localparam logic [3:0] SLOT_A = 4'h0;
    localparam logic [3:0] SLOT_B = 4'h1;
    localparam logic [3:0] SLOT_C = 4'h2;
    localparam logic [3:0] SLOT_D = 4'h3;
    localparam logic [3:0] SLOT_E = 4'h4;
    localparam logic [3:0] SLOT_M = 4'hC;
    localparam logic [3:0] SLOT_LAST = 4'hD;

    // Channel kinds, one designation counter each
    localparam int KIND_INPUT = 0;
    localparam int KIND_OUTPUT = 1;
    localparam int KIND_SENSOR = 2;
    localparam int KIND_FAST_OUT = 3;
    localparam int KIND_ARC_INPUT = 4;

    localparam logic [7:0] FIRST_DSG = 8'h01;
    localparam logic [7:0] CPU_INPUT_CNT = 8'h03;
    localparam logic [7:0] CPU_OUTPUT_CNT = 8'h05;
    localparam logic [7:0] EIGHT_INPUT_CNT = 8'h08;
    localparam logic [7:0] FIVE_OUTPUT_CNT = 8'h05;
    localparam logic [7:0] ARC_SENSOR_CNT = 8'h04;
    localparam logic [7:0] ARC_FAST_OUT_CNT = 8'h02;
    localparam logic [7:0] ARC_INPUT_CNT = 8'h01;

    typedef logic [DSG_W-1:0] ssn_dsg_t;

    typedef enum logic [3:0] {
        NO_CARD = 4'h0,
        EIGHT_INPUT_CARD = 4'h1,
        FIVE_OUTPUT_CARD = 4'h2,
        FIVE_OUTPUT_CARD_ALT = 4'h3,
        ARC_CARD = 4'h4,
        VOLTAGE_MEASUREMENT_CARD = 4'h5,
        CURRENT_MEASUREMENT_CARD = 4'h6,
        COMM_CARD = 4'h7,
        OTHER_CARD = 4'h8
    } ssn_card_t;

    typedef enum logic [4:0] {
        ST_CPU = 5'h01,
        ST_SEL = 5'h02,
        ST_WAIT = 5'h04,
        ST_EVAL = 5'h08,
        ST_DONE = 5'h10
    } ssn_state_t;

    typedef struct packed {
        logic [3:0] slot;
        ssn_card_t card;
        ssn_dsg_t [NUM_KINDS-1:0] first;
    } ssn_assign_t;

    typedef struct packed {
        logic cpu_fail;
        logic volt_missing;
        logic slot_b_used;
        logic curr_missing;
        logic [NUM_SLOTS-1:0] missing;
        logic [NUM_SLOTS-1:0] mismatch;
    } ssn_alarm_t;

    // Channels of one kind that a card brings
    function automatic ssn_dsg_t kind_count(ssn_card_t card, int kind);
        ssn_dsg_t n;
        n = '0;
        case (card)
            EIGHT_INPUT_CARD: begin
                if (kind == KIND_INPUT) n = EIGHT_INPUT_CNT;
            end
            FIVE_OUTPUT_CARD, FIVE_OUTPUT_CARD_ALT: begin
                if (kind == KIND_OUTPUT) n = FIVE_OUTPUT_CNT;
            end
            ARC_CARD: begin
                if (kind == KIND_SENSOR) n = ARC_SENSOR_CNT;
                else if (kind == KIND_FAST_OUT) n = ARC_FAST_OUT_CNT;
                else if (kind == KIND_ARC_INPUT) n = ARC_INPUT_CNT;
            end
            default: n = '0;
        endcase
        return n;
    endfunction

endpackage

//--- logic/ssn_dsg_alloc.sv
`timescale 1ns/1ps
module ssn_dsg_alloc #(
    parameter int W = 8
) (
    input logic clk,
    input logic rst_n,
    input logic reserve,
    input logic [W-1:0] count,
    output logic [W-1:0] base
);

    logic [W-1:0] next_q;

    // Each group starts where the last one ended, so numbers stay contiguous
    // contiguous numbering
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            next_q <= W'(ssn_pkg::FIRST_DSG);
        end else if (reserve) begin
            next_q <= next_q + count;
        end
    end

    assign base = next_q;

endmodule

//--- logic/ssn_slot_check.sv
`timescale 1ns/1ps
module ssn_slot_check (
    input logic [3:0] slot,
    input logic present,
    input ssn_pkg::ssn_card_t detected,
    input ssn_pkg::ssn_card_t expected,
    output logic accept,
    output logic missing,
    output logic mismatch
);

    always_comb begin
        ssn_pkg::ssn_card_t fixed;
        fixed = (slot == ssn_pkg::SLOT_A) ?
            ssn_pkg::VOLTAGE_MEASUREMENT_CARD :
            ssn_pkg::CURRENT_MEASUREMENT_CARD;
        accept = 1'b0;
        missing = 1'b0;
        mismatch = 1'b0;
        if (slot == ssn_pkg::SLOT_A || slot == ssn_pkg::SLOT_D) begin
            if (!present) missing = 1'b1;
            else if (detected != fixed) mismatch = 1'b1;
            else accept = 1'b1;
        end else if (slot == ssn_pkg::SLOT_B) begin
            mismatch = present;
        end else if (!present) begin
            missing = (expected != ssn_pkg::NO_CARD);
        // comm cards only in M and N
        end else if (detected == ssn_pkg::COMM_CARD &&
                     slot < ssn_pkg::SLOT_M) begin
            mismatch = 1'b1;
        end else if (detected != expected ||
                     detected == ssn_pkg::NO_CARD ||
                     detected == ssn_pkg::VOLTAGE_MEASUREMENT_CARD ||
                     detected == ssn_pkg::CURRENT_MEASUREMENT_CARD) begin
            mismatch = 1'b1;
        end else begin
            accept = 1'b1;
        end
    end

endmodule

//--- logic/ssn_scan_top.sv
// Behaviour
// - Fourteen slots; comm cards only in M, N
// - Identify modules; config difference raises error
// - Scan CPU first, then slots in order
// - CPU gets inputs 1-3, outputs 1-5
// - Slot A needs voltage card, else alarm
// - Slot B must be empty, else alarm
// - Empty C skipped; eight-input takes 4-11
// - Five-output card in C takes 6-10
// - Add I/O only on matching type code
// - Expected but absent module raises alarm
// - Slot D needs current card, else alarm
// - E inputs follow C: 4-11 or 12-19
// - E outputs follow C: 6-10 or 11-15
// - Arc card: four sensors, two fast, one input
// - Later slots number after earlier reservations
`timescale 1ns/1ps
module ssn_scan_top (
    input logic clk,
    input logic rst_n,
    input logic cpu_selftest_ok,
    input ssn_pkg::ssn_card_t [ssn_pkg::NUM_SLOTS-1:0] cfg_expect,
    input logic slot_present,
    input ssn_pkg::ssn_card_t slot_card,
    output logic [3:0] slot_sel_q,
    output logic slot_probe_q,
    output logic assign_valid_q,
    output ssn_pkg::ssn_assign_t assign_q,
    output ssn_pkg::ssn_alarm_t alarm_q,
    output logic hw_cfg_error_q,
    output logic scan_done_q
);

    localparam int K = ssn_pkg::NUM_KINDS;

    ssn_pkg::ssn_state_t state_q;
    ssn_pkg::ssn_state_t state_d;
    logic [3:0] step_q;
    logic accept;
    logic missing;
    logic mismatch;
    logic eval;
    logic [K-1:0] rsv;
    ssn_pkg::ssn_dsg_t [K-1:0] rsv_cnt;
    ssn_pkg::ssn_dsg_t [K-1:0] base;
    logic c_in_q;
    logic c_out_q;

    assign eval = (state_q == ssn_pkg::ST_EVAL);

    ssn_slot_check u_check (
        .slot(step_q),
        .present(slot_present),
        .detected(slot_card),
        .expected(cfg_expect[step_q]),
        .accept(accept),
        .missing(missing),
        .mismatch(mismatch)
    );

    for (genvar k = 0; k < K; k++) begin : g_alloc
        ssn_dsg_alloc #(.W(ssn_pkg::DSG_W)) u_alloc (
            .clk(clk),
            .rst_n(rst_n),
            .reserve(rsv[k]),
            .count(rsv_cnt[k]),
            .base(base[k])
        );
    end

    always_comb begin
        case (state_q)
            ssn_pkg::ST_CPU: state_d = ssn_pkg::ST_SEL;
            ssn_pkg::ST_SEL: state_d = ssn_pkg::ST_WAIT;
            ssn_pkg::ST_WAIT: state_d = ssn_pkg::ST_EVAL;
            ssn_pkg::ST_EVAL: begin
                state_d = (step_q == ssn_pkg::SLOT_LAST) ?
                    ssn_pkg::ST_DONE : ssn_pkg::ST_SEL;
            end
            ssn_pkg::ST_DONE: state_d = ssn_pkg::ST_DONE;
            default: state_d = ssn_pkg::ST_CPU;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ssn_pkg::ST_CPU;
        end else begin
            state_q <= state_d;
        end
    end

    // slots walked one by one, A through N
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step_q <= ssn_pkg::SLOT_A;
        end else if (eval && step_q != ssn_pkg::SLOT_LAST) begin
            step_q <= step_q + 4'h1;
        end
    end

    // The select is held a full cycle before sampling so the slot settles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_sel_q <= 4'h0;
            slot_probe_q <= 1'b0;
        end else if (state_q == ssn_pkg::ST_SEL) begin
            slot_sel_q <= step_q;
            slot_probe_q <= 1'b1;
        end else if (eval) begin
            slot_probe_q <= 1'b0;
        end
    end

    always_comb begin
        for (int k = 0; k < K; k++) begin
            rsv_cnt[k] = '0;
        end
        if (state_q == ssn_pkg::ST_CPU && cpu_selftest_ok) begin
            rsv_cnt[ssn_pkg::KIND_INPUT] = ssn_pkg::CPU_INPUT_CNT;
            rsv_cnt[ssn_pkg::KIND_OUTPUT] = ssn_pkg::CPU_OUTPUT_CNT;
        end else if (eval && accept) begin
            for (int k = 0; k < K; k++) begin
                rsv_cnt[k] = ssn_pkg::kind_count(slot_card, k);
            end
        end
        for (int k = 0; k < K; k++) begin
            rsv[k] = (rsv_cnt[k] != '0);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            assign_valid_q <= 1'b0;
            assign_q <= '0;
        end else begin
            assign_valid_q <= eval && accept;
            if (eval && accept) begin
                assign_q.slot <= step_q;
                assign_q.card <= slot_card;
                assign_q.first <= base;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_q <= '0;
        end else begin
            if (state_q == ssn_pkg::ST_CPU && !cpu_selftest_ok) begin
                alarm_q.cpu_fail <= 1'b1;
            end
            if (eval && (missing || mismatch)) begin
                if (step_q == ssn_pkg::SLOT_A) alarm_q.volt_missing <= 1'b1;
                if (step_q == ssn_pkg::SLOT_B) alarm_q.slot_b_used <= 1'b1;
                if (step_q == ssn_pkg::SLOT_D) alarm_q.curr_missing <= 1'b1;
                if (missing) alarm_q.missing[step_q] <= 1'b1;
                if (mismatch) alarm_q.mismatch[step_q] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hw_cfg_error_q <= 1'b0;
        end else if ((state_q == ssn_pkg::ST_CPU && !cpu_selftest_ok) ||
                     (eval && (missing || mismatch))) begin
            hw_cfg_error_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_done_q <= 1'b0;
        end else if (state_d == ssn_pkg::ST_DONE) begin
            scan_done_q <= 1'b1;
        end
    end

    // Helper state for checking how slot E numbers after slot C
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            c_in_q <= 1'b0;
            c_out_q <= 1'b0;
        end else if (eval && accept && step_q == ssn_pkg::SLOT_C) begin
            c_in_q <= (slot_card == ssn_pkg::EIGHT_INPUT_CARD);
            c_out_q <= ssn_pkg::kind_count(slot_card,
                ssn_pkg::KIND_OUTPUT) != '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    cpu_numbers_a: assert property (
        state_q == ssn_pkg::ST_CPU && cpu_selftest_ok |=>
        base[ssn_pkg::KIND_INPUT] ==
            ssn_pkg::FIRST_DSG + ssn_pkg::CPU_INPUT_CNT &&
        base[ssn_pkg::KIND_OUTPUT] ==
            ssn_pkg::FIRST_DSG + ssn_pkg::CPU_OUTPUT_CNT)
        else $error("CPU designations not reserved");

    scan_order_a: assert property (
        state_q == ssn_pkg::ST_SEL |=>
        state_q == ssn_pkg::ST_WAIT && slot_sel_q == step_q ##1
        state_q == ssn_pkg::ST_EVAL && slot_probe_q)
        else $error("Scan step sequence broken");

    slot_a_alarm_a: assert property (
        eval && step_q == ssn_pkg::SLOT_A &&
        !(slot_present && slot_card == ssn_pkg::VOLTAGE_MEASUREMENT_CARD)
        |=> alarm_q.volt_missing && hw_cfg_error_q)
        else $error("Voltage card absence not flagged");

    slot_b_alarm_a: assert property (
        eval && step_q == ssn_pkg::SLOT_B && slot_present
        |=> alarm_q.slot_b_used && !assign_valid_q)
        else $error("Occupied slot B not flagged");

    slot_d_alarm_a: assert property (
        eval && step_q == ssn_pkg::SLOT_D && !slot_present
        |=> alarm_q.curr_missing && alarm_q.missing[ssn_pkg::SLOT_D])
        else $error("Current card absence not flagged");

    c_input_a: assert property (
        eval && accept && step_q == ssn_pkg::SLOT_C && cpu_selftest_ok &&
        slot_card == ssn_pkg::EIGHT_INPUT_CARD |=> assign_valid_q &&
        assign_q.first[ssn_pkg::KIND_INPUT] ==
            ssn_pkg::FIRST_DSG + ssn_pkg::CPU_INPUT_CNT)
        else $error("Slot C inputs misnumbered");

    // Both five-output variants share one numbering rule
    c_output_a: assert property (
        eval && accept && step_q == ssn_pkg::SLOT_C && cpu_selftest_ok &&
        (slot_card == ssn_pkg::FIVE_OUTPUT_CARD ||
         slot_card == ssn_pkg::FIVE_OUTPUT_CARD_ALT) |=>
        assign_q.first[ssn_pkg::KIND_OUTPUT] ==
            ssn_pkg::FIRST_DSG + ssn_pkg::CPU_OUTPUT_CNT)
        else $error("Slot C outputs misnumbered");

    e_input_a: assert property (
        eval && accept && step_q == ssn_pkg::SLOT_E &&
        slot_card == ssn_pkg::EIGHT_INPUT_CARD && cpu_selftest_ok
        |=> assign_q.first[ssn_pkg::KIND_INPUT] ==
            ssn_pkg::FIRST_DSG + ssn_pkg::CPU_INPUT_CNT +
            (c_in_q ? ssn_pkg::EIGHT_INPUT_CNT : 8'h00))
        else $error("Slot E inputs misnumbered");

    e_output_a: assert property (
        eval && accept && step_q == ssn_pkg::SLOT_E &&
        (slot_card == ssn_pkg::FIVE_OUTPUT_CARD ||
         slot_card == ssn_pkg::FIVE_OUTPUT_CARD_ALT) && cpu_selftest_ok
        |=> assign_q.first[ssn_pkg::KIND_OUTPUT] ==
            ssn_pkg::FIRST_DSG + ssn_pkg::CPU_OUTPUT_CNT +
            (c_out_q ? ssn_pkg::FIVE_OUTPUT_CNT : 8'h00))
        else $error("Slot E outputs misnumbered");

    arc_groups_a: assert property (
        eval && accept && slot_card == ssn_pkg::ARC_CARD |=>
        base[ssn_pkg::KIND_SENSOR] == $past(base[ssn_pkg::KIND_SENSOR])
            + ssn_pkg::ARC_SENSOR_CNT &&
        base[ssn_pkg::KIND_FAST_OUT] ==
            $past(base[ssn_pkg::KIND_FAST_OUT]) + ssn_pkg::ARC_FAST_OUT_CNT)
        else $error("Arc card groups not reserved");

    contiguous_a: assert property (
        eval && accept && step_q > ssn_pkg::SLOT_D |=>
        base[ssn_pkg::KIND_INPUT] == $past(base[ssn_pkg::KIND_INPUT]) +
            ssn_pkg::kind_count($past(slot_card), ssn_pkg::KIND_INPUT))
        else $error("Input numbering not contiguous");

    mismatch_a: assert property (
        eval && mismatch |=> !assign_valid_q &&
        alarm_q.mismatch[$past(step_q)] && hw_cfg_error_q)
        else $error("Mismatch added channels or gave no alarm");

    missing_a: assert property (
        eval && step_q > ssn_pkg::SLOT_D && !slot_present &&
        cfg_expect[step_q] != ssn_pkg::NO_CARD
        |=> alarm_q.missing[$past(step_q)])
        else $error("Expected module absence not flagged");

    comm_slot_a: assert property (
        eval && slot_present && slot_card == ssn_pkg::COMM_CARD &&
        step_q < ssn_pkg::SLOT_M |=> !assign_valid_q)
        else $error("Comm card accepted outside M and N");

    scan_done_c: cover property (scan_done_q && !hw_cfg_error_q);
    e_after_c_c: cover property (
        eval && accept && step_q == ssn_pkg::SLOT_E && c_in_q);
    arc_card_c: cover property (
        eval && accept && slot_card == ssn_pkg::ARC_CARD);
    mismatch_c: cover property (eval && mismatch);

endmodule

//--- test/ssn_slot_model.sv
`timescale 1ns/1ps
module ssn_slot_model (
    input logic clk,
    input logic rst_n,
    input logic [3:0] slot_sel_q,
    input logic slot_probe_q,
    input ssn_pkg::ssn_card_t [ssn_pkg::NUM_SLOTS-1:0] installed,
    output logic slot_present,
    output ssn_pkg::ssn_card_t slot_card
);
    logic junk_q;

    // Idle lines churn so a stale sample never looks valid
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            junk_q <= 1'b0;
        end else begin
            junk_q <= ~junk_q;
        end
    end

    always_comb begin
        if (slot_probe_q && slot_sel_q < 4'hE) begin
            slot_card = installed[slot_sel_q];
            slot_present = installed[slot_sel_q] != ssn_pkg::NO_CARD;
        end else begin
            slot_present = junk_q;
            slot_card = junk_q ? ssn_pkg::OTHER_CARD : ssn_pkg::COMM_CARD;
        end
    end
endmodule

//--- test/ssn_scan_top_bench.sv
`timescale 1ns/1ps
module ssn_scan_top_bench;
    typedef struct {
        logic [3:0] slot;
        ssn_pkg::ssn_card_t card;
        logic [4:0] used;
        ssn_pkg::ssn_dsg_t [4:0] first;
    } ssn_note_t;

    localparam int NS = ssn_pkg::NUM_SLOTS;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cpu_selftest_ok = 1'b1;
    logic cpu_ok;
    ssn_pkg::ssn_card_t [NS-1:0] cfg_expect;
    ssn_pkg::ssn_card_t [NS-1:0] inst_w;
    ssn_pkg::ssn_card_t [NS-1:0] inst;
    ssn_pkg::ssn_card_t [NS-1:0] cfg;
    logic slot_present;
    ssn_pkg::ssn_card_t slot_card;
    logic [3:0] slot_sel_q;
    logic slot_probe_q;
    logic assign_valid_q;
    ssn_pkg::ssn_assign_t assign_q;
    ssn_pkg::ssn_alarm_t alarm_q;
    ssn_pkg::ssn_alarm_t exp_alarm;
    logic hw_cfg_error_q;
    logic scan_done_q;
    ssn_note_t q[$];
    ssn_note_t n;
    int miscompares = 0;
    int checked = 0;

    always #12.5 clk = ~clk;

    ssn_scan_top uut (.clk(clk), .rst_n(rst_n),
        .cpu_selftest_ok(cpu_selftest_ok), .cfg_expect(cfg_expect),
        .slot_present(slot_present), .slot_card(slot_card),
        .slot_sel_q(slot_sel_q), .slot_probe_q(slot_probe_q),
        .assign_valid_q(assign_valid_q), .assign_q(assign_q),
        .alarm_q(alarm_q), .hw_cfg_error_q(hw_cfg_error_q),
        .scan_done_q(scan_done_q));

    ssn_slot_model partner (.clk(clk), .rst_n(rst_n),
        .slot_sel_q(slot_sel_q), .slot_probe_q(slot_probe_q),
        .installed(inst_w), .slot_present(slot_present),
        .slot_card(slot_card));

    function automatic ssn_pkg::ssn_dsg_t cnt(ssn_pkg::ssn_card_t c,
                                              int k);
        case (c)
            ssn_pkg::EIGHT_INPUT_CARD: return k == 0 ? 8'h08 : 8'h00;
            ssn_pkg::FIVE_OUTPUT_CARD,
            ssn_pkg::FIVE_OUTPUT_CARD_ALT: return k == 1 ? 8'h05 : 8'h00;
            ssn_pkg::ARC_CARD: return k == 2 ? 8'h04 : k == 3 ? 8'h02 :
                k == 4 ? 8'h01 : 8'h00;
            default: return 8'h00;
        endcase
    endfunction

    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Expected pulses and flags for the current slot contents
    task automatic plan();
        ssn_pkg::ssn_dsg_t nxt [5];
        ssn_note_t e;
        ssn_pkg::ssn_card_t c;
        logic ok;
        for (int k = 0; k < 5; k++) nxt[k] = 8'h01;
        exp_alarm = '0;
        if (cpu_ok) begin
            nxt[0] += 8'h03;
            nxt[1] += 8'h05;
        end else begin
            exp_alarm.cpu_fail = 1'b1;
        end
        for (int s = 0; s < NS; s++) begin
            c = inst[s];
            if (s == 0) ok = c == ssn_pkg::VOLTAGE_MEASUREMENT_CARD;
            else if (s == 3) ok = c == ssn_pkg::CURRENT_MEASUREMENT_CARD;
            else if (s == 1) ok = 1'b0;
            else ok = c == cfg[s] && c != ssn_pkg::NO_CARD &&
                c != ssn_pkg::VOLTAGE_MEASUREMENT_CARD &&
                c != ssn_pkg::CURRENT_MEASUREMENT_CARD &&
                (c != ssn_pkg::COMM_CARD || s >= 12);
            if (c != ssn_pkg::NO_CARD && !ok) exp_alarm.mismatch[s] = 1'b1;
            if (c == ssn_pkg::NO_CARD && s != 1 &&
                (s == 0 || s == 3 || cfg[s] != ssn_pkg::NO_CARD))
                exp_alarm.missing[s] = 1'b1;
            if (s == 0 && !ok) exp_alarm.volt_missing = 1'b1;
            if (s == 3 && !ok) exp_alarm.curr_missing = 1'b1;
            if (s == 1 && c != ssn_pkg::NO_CARD) exp_alarm.slot_b_used = 1'b1;
            if (ok) begin
                e.slot = 4'(s);
                e.card = c;
                for (int k = 0; k < 5; k++) begin
                    e.first[k] = nxt[k];
                    e.used[k] = cnt(c, k) != 8'h00;
                    nxt[k] += cnt(c, k);
                end
                q.push_back(e);
            end
        end
    endtask

    always @(negedge clk) begin
        if (rst_n === 1'b1 && assign_valid_q === 1'b1) begin
            if (q.size() == 0) begin
                chk(1'b0, "assign pulse with none due");
            end else begin
                n = q.pop_front();
                chk(assign_q.slot === n.slot, "slot order");
                chk(assign_q.card === n.card, "card code");
                for (int k = 0; k < 5; k++)
                    if (n.used[k])
                        chk(assign_q.first[k] === n.first[k], "first");
            end
        end
    end

    task automatic start_scan();
        @(posedge clk);
        rst_n <= 1'b0;
        inst_w <= inst;
        cfg_expect <= cfg;
        cpu_selftest_ok <= cpu_ok;
        q.delete();
        plan();
        repeat (5) @(posedge clk);
        chk(scan_done_q === 1'b0 && alarm_q === '0, "reset state");
        rst_n <= 1'b1;
    endtask

    task automatic finish_scan(input string name);
        int i;
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (scan_done_q !== 1'b1 && i < 60);
        if (i >= 60) begin
            chk(1'b0, "scan never finished");
            tally_and_finish();
        end
        // Let the monitor take the last slot's pulse before counting notes
        @(posedge clk);
        chk(i == 44, "scan length");
        chk(alarm_q === exp_alarm, "alarm flags");
        chk(hw_cfg_error_q === (exp_alarm != '0), "config error");
        chk(q.size() == 0, "assign pulse missing");
        $display("test %s done", name);
    endtask

    task automatic std_cards();
        cpu_ok = 1'b1;
        for (int s = 0; s < NS; s++) inst[s] = ssn_pkg::NO_CARD;
        inst[0] = ssn_pkg::VOLTAGE_MEASUREMENT_CARD;
        inst[3] = ssn_pkg::CURRENT_MEASUREMENT_CARD;
        cfg = inst;
    endtask

    ssn_pkg::ssn_card_t picks [6] = '{ssn_pkg::NO_CARD,
        ssn_pkg::EIGHT_INPUT_CARD, ssn_pkg::FIVE_OUTPUT_CARD,
        ssn_pkg::FIVE_OUTPUT_CARD_ALT, ssn_pkg::ARC_CARD,
        ssn_pkg::COMM_CARD};

    initial begin
        void'($urandom(19606));
        std_cards();
        inst[2] = picks[1];
        inst[4] = picks[1];
        inst[5] = picks[2];
        inst[6] = picks[4];
        inst[7] = picks[3];
        inst[8] = ssn_pkg::OTHER_CARD;
        inst[12] = picks[5];
        cfg = inst;
        start_scan();
        finish_scan("inputs after inputs");
        std_cards();
        inst[2] = picks[2];
        inst[4] = picks[3];
        inst[5] = picks[4];
        inst[6] = picks[1];
        inst[13] = picks[5];
        cfg = inst;
        start_scan();
        finish_scan("outputs after outputs");
        std_cards();
        cpu_ok = 1'b0;
        inst[0] = picks[0];
        inst[1] = picks[1];
        inst[2] = picks[2];
        inst[3] = picks[4];
        inst[5] = picks[5];
        inst[6] = picks[1];
        inst[7] = picks[3];
        inst[9] = ssn_pkg::CURRENT_MEASUREMENT_CARD;
        cfg = inst;
        cfg[2] = picks[1];
        cfg[4] = picks[4];
        cfg[7] = picks[0];
        start_scan();
        finish_scan("faults");
        for (int r = 0; r < 4; r++) begin
            std_cards();
            for (int s = 2; s < NS; s++)
                if (s != 3) inst[s] = picks[$urandom % (s >= 12 ? 6 : 5)];
            cfg = inst;
            start_scan();
            finish_scan("random fill");
        end
        std_cards();
        inst[2] = picks[1];
        cfg = inst;
        start_scan();
        repeat (20) @(negedge clk);
        start_scan();
        finish_scan("reset mid-scan");
        tally_and_finish();
    end
endmodule
